// ### hdl/flash_regs_pkg.sv
package flash_regs_pkg;
  // Register indexes; the byte address on the bus is four times the index.
  localparam int AXI_AW = 10;
  localparam logic [7:0] IDX_CHIP_CTRL = 8'h9F;
  localparam logic [7:0] IDX_TRIGGER = 8'hA4;
  localparam logic [7:0] IDX_UPD_EN = 8'hA5;
  localparam logic [7:0] IDX_ADDR_LO = 8'hA6;
  localparam logic [7:0] IDX_ADDR_HI = 8'hA7;
  localparam logic [7:0] IDX_BUFFER = 8'hAE;
  localparam logic [7:0] IDX_COMMAND = 8'hAF;
  localparam logic [7:0] IDX_UNLOCK = 8'hC7;
  localparam logic [7:0] IDX_IRQ_STAT = 8'hF0;
  localparam logic [7:0] IDX_IRQ_MASK = 8'hF1;
  // Reset values.
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RST_IRQ = 2'h0;
  // Unlock key bytes.
  localparam logic [7:0] KEY_FIRST = 8'hAA;
  localparam logic [7:0] KEY_SECOND = 8'h55;
  // Bit positions.
  localparam int GO_BIT = 0;
  localparam int ENABLE_BIT = 0;
  localparam int FAIL_BIT = 6;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_FAIL_BIT = 1;
  // Command field layout and codes.
  localparam int CMD_AREA_LSB = 6;
  localparam int CMD_WRITE_EN_BIT = 5;
  localparam int CMD_EXT_BIT = 4;
  localparam logic [3:0] OP_READ = 4'h0;
  localparam logic [3:0] OP_PROGRAM = 4'h1;
  localparam logic [3:0] OP_ERASE = 4'h2;
  localparam logic [1:0] AREA_UNUSED = 2'h2;
  localparam int PAGE_BYTES = 128;
  // Bus responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Timing, rounded up to whole cycles.
  localparam int CLK_PERIOD_NS = 5;
  localparam int ERASE_TIME_NS = 5000000;
  localparam int PROGRAM_TIME_NS = 23500;
  localparam int READ_TIME_NS = 20;
  localparam int ERASE_CYC = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROGRAM_CYC = (PROGRAM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_CYC = (READ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// ### hdl/flash_op_if.sv
`timescale 1ns/1ps
`default_nettype none
interface flash_op_if;
  logic start;
  logic [7:0] cmd;
  logic [15:0] addr;
  logic [7:0] wdata;
  logic [2:0] upd_en;
  logic done;
  logic fail;
  logic [7:0] rdata;
  modport regs (output start, cmd, addr, wdata, upd_en, input done, fail, rdata);
  modport eng (input start, cmd, addr, wdata, upd_en, output done, fail, rdata);
endinterface
`default_nettype wire

// ### hdl/flash_op_engine.sv
`timescale 1ns/1ps
`default_nettype none
module flash_op_engine
  import flash_regs_pkg::*;
#(
  parameter int AREA_AW = 10,
  parameter int ERASE_CYCLES = ERASE_CYC,
  parameter int PROGRAM_CYCLES = PROGRAM_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Operation port
  flash_op_if.eng op
);
  typedef enum {ST_IDLE, ST_RUN} eng_state_e;
  eng_state_e state_r, state_nxt;
  logic [31:0] cnt_r, cnt_nxt;
  logic [7:0] idx_r, idx_nxt;
  logic [3:0] opc_r, opc_nxt;
  logic done_r, done_nxt, fail_r, fail_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [7:0] mem [4 * (2 ** AREA_AW)];
  logic mem_we;
  logic [AREA_AW+1:0] mem_a;
  logic [7:0] mem_d;
  logic [AREA_AW+1:0] base;
  logic [3:0] op_sel;
  logic [1:0] area;
  logic valid;

  assign op_sel = op.cmd[3:0];
  assign area = op.cmd[CMD_AREA_LSB +: 2];
  assign base = {area, op.addr[AREA_AW-1:0]};

  always_comb begin
    // Out-of-range address, bad command or a program or erase in a locked area all fail.
    valid = (op.addr < 16'((2 ** AREA_AW))) && !op.cmd[CMD_EXT_BIT] && (area != AREA_UNUSED)
      && (op_sel == OP_READ || op_sel == OP_PROGRAM || op_sel == OP_ERASE)
      && (op.cmd[CMD_WRITE_EN_BIT] == (op_sel != OP_READ))
      && (op_sel == OP_READ || op.upd_en[(area == 2'h3) ? 2 : area]);
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    idx_nxt = idx_r;
    opc_nxt = opc_r;
    done_nxt = 1'b0;
    fail_nxt = 1'b0;
    rdata_nxt = rdata_r;
    mem_we = 1'b0;
    mem_a = base;
    mem_d = op.wdata;
    case (state_r)
      ST_IDLE: begin
        if (op.start) begin
          if (!valid) begin
            done_nxt = 1'b1;
            fail_nxt = 1'b1;
          end else begin
            state_nxt = ST_RUN;
            opc_nxt = op_sel;
            idx_nxt = 8'h00;
            cnt_nxt = (op_sel == OP_ERASE) ? 32'(ERASE_CYCLES) :
              (op_sel == OP_PROGRAM) ? 32'(PROGRAM_CYCLES) : 32'(READ_CYC);
          end
        end
      end
      ST_RUN: begin
        // Erase walks the page one byte per cycle while the timer runs.
        if (opc_r == OP_ERASE && idx_r < 8'(PAGE_BYTES)) begin
          mem_we = 1'b1;
          mem_a = {base[AREA_AW+1:7], idx_r[6:0]};
          mem_d = 8'hFF;
          idx_nxt = idx_r + 8'h01;
        end
        if (cnt_r > 32'h1) begin
          cnt_nxt = cnt_r - 32'h1;
        end else if (opc_r != OP_ERASE || idx_r >= 8'(PAGE_BYTES)) begin
          state_nxt = ST_IDLE;
          done_nxt = 1'b1;
          if (opc_r == OP_READ) begin
            rdata_nxt = mem[base];
          end
          if (opc_r == OP_PROGRAM) begin
            mem_we = 1'b1;
          end
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= ST_IDLE;
      cnt_r <= 32'h0;
      idx_r <= 8'h00;
      opc_r <= OP_READ;
      done_r <= 1'b0;
      fail_r <= 1'b0;
      rdata_r <= RST_BYTE;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      idx_r <= idx_nxt;
      opc_r <= opc_nxt;
      done_r <= done_nxt;
      fail_r <= fail_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // The array models non-volatile cells, so reset leaves it alone.
  always_ff @(posedge aclk) begin
    if (mem_we) begin
      mem[mem_a] <= mem_d;
    end
  end

  assign op.done = done_r;
  assign op.fail = fail_r;
  assign op.rdata = rdata_r;
endmodule // flash_op_engine
`default_nettype wire

// ### hdl/flash_self_program_regs.sv
`timescale 1ns/1ps
`default_nettype none
module flash_self_program_regs
  import flash_regs_pkg::*;
#(
  parameter int AREA_AW = 10,
  parameter int ERASE_CYCLES = ERASE_CYC,
  parameter int PROGRAM_CYCLES = PROGRAM_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write address channel
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // Write data channel
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // Write response channel
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read address channel
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // Read data channel
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Core side
  output logic cpu_hold,
  output logic irq
);
  typedef enum {KEY_IDLE, KEY_HALF, KEY_ARMED} key_state_e;

  flash_op_if op ();

  key_state_e key_r, key_nxt;
  logic aw_full_r, aw_full_nxt, w_full_r, w_full_nxt;
  logic [AXI_AW-1:0] aw_addr_r, aw_addr_nxt;
  logic [7:0] w_byte_r, w_byte_nxt;
  logic w_lane_r, w_lane_nxt;
  logic awready_r, awready_nxt, wready_r, wready_nxt;
  logic bvalid_r, bvalid_nxt, arready_r, arready_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [AXI_AW-1:0] rd_addr_r, rd_addr_nxt;
  logic [7:0] addr_hi_r, addr_hi_nxt, addr_lo_r, addr_lo_nxt;
  logic [7:0] buffer_r, buffer_nxt, command_r, command_nxt;
  logic [2:0] upd_en_r, upd_en_nxt;
  logic enable_r, enable_nxt, fail_r, fail_nxt;
  logic hold_r, hold_nxt, start_r, start_nxt;
  logic [1:0] irq_stat_r, irq_stat_nxt, irq_mask_r, irq_mask_nxt;
  logic irq_r, irq_nxt;
  logic wr_fire, wr_hit, rd_fire, rd_hit;
  logic [7:0] wr_idx, rd_idx;
  logic [7:0] rd_byte;
  logic [1:0] irq_set;

  flash_op_engine #(
    .AREA_AW(AREA_AW),
    .ERASE_CYCLES(ERASE_CYCLES),
    .PROGRAM_CYCLES(PROGRAM_CYCLES)
  ) u_engine (
    .aclk(aclk),
    .aresetn(aresetn),
    .op(op)
  );

  assign op.start = start_r;
  assign op.cmd = command_r;
  assign op.addr = {addr_hi_r, addr_lo_r};
  assign op.wdata = buffer_r;
  assign op.upd_en = upd_en_r;

  always_comb begin
    wr_fire = aw_full_r && w_full_r && !bvalid_r;
    rd_fire = s_axi_arvalid && arready_r;
    wr_idx = aw_addr_r[AXI_AW-1:2];
    rd_idx = s_axi_araddr[AXI_AW-1:2];
    wr_hit = 1'b1;
    rd_hit = 1'b1;
    irq_set = 2'h0;
    irq_set[IRQ_DONE_BIT] = op.done;
    irq_set[IRQ_FAIL_BIT] = op.done && op.fail;
    aw_full_nxt = aw_full_r;
    aw_addr_nxt = aw_addr_r;
    w_full_nxt = w_full_r;
    w_byte_nxt = w_byte_r;
    w_lane_nxt = w_lane_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    rd_addr_nxt = rd_addr_r;
    key_nxt = key_r;
    addr_hi_nxt = addr_hi_r;
    addr_lo_nxt = addr_lo_r;
    buffer_nxt = buffer_r;
    command_nxt = command_r;
    upd_en_nxt = upd_en_r;
    enable_nxt = enable_r;
    fail_nxt = fail_r;
    hold_nxt = hold_r;
    start_nxt = 1'b0;
    irq_stat_nxt = irq_stat_r;
    irq_mask_nxt = irq_mask_r;
    rd_byte = 8'h00;

    if (s_axi_awvalid && awready_r) begin
      aw_full_nxt = 1'b1;
      aw_addr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_r) begin
      w_full_nxt = 1'b1;
      w_byte_nxt = s_axi_wdata[7:0];
      w_lane_nxt = s_axi_wstrb[0];
    end
    if (s_axi_bvalid && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end

    if (wr_fire) begin
      aw_full_nxt = 1'b0;
      w_full_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      // Any write other than the second key byte drops the unlock.
      key_nxt = KEY_IDLE;
      case (wr_idx)
        IDX_UNLOCK: begin
          if (w_lane_r && w_byte_r == KEY_FIRST) begin
            key_nxt = KEY_HALF;
          end else if (w_lane_r && w_byte_r == KEY_SECOND && key_r == KEY_HALF) begin
            key_nxt = KEY_ARMED;
          end
        end
        IDX_TRIGGER: begin
          // A locked, disabled or busy write is accepted but has no effect.
          if (w_lane_r && w_byte_r[GO_BIT] && key_r == KEY_ARMED && enable_r && !hold_r) begin
            start_nxt = 1'b1;
            hold_nxt = 1'b1;
          end
        end
        IDX_CHIP_CTRL: begin
          if (w_lane_r && key_r == KEY_ARMED) begin
            enable_nxt = w_byte_r[ENABLE_BIT];
            fail_nxt = fail_r & w_byte_r[FAIL_BIT];
          end
        end
        IDX_UPD_EN: if (w_lane_r && key_r == KEY_ARMED) upd_en_nxt = w_byte_r[2:0];
        IDX_ADDR_HI: if (w_lane_r && !hold_r) addr_hi_nxt = w_byte_r;
        IDX_ADDR_LO: if (w_lane_r && !hold_r) addr_lo_nxt = w_byte_r;
        IDX_BUFFER: if (w_lane_r && !hold_r) buffer_nxt = w_byte_r;
        IDX_COMMAND: if (w_lane_r && !hold_r) command_nxt = w_byte_r;
        IDX_IRQ_MASK: if (w_lane_r) irq_mask_nxt = w_byte_r[1:0];
        IDX_IRQ_STAT: wr_hit = 1'b1;
        default: wr_hit = 1'b0;
      endcase
      bresp_nxt = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end

    if (s_axi_rvalid && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    if (rd_fire) begin
      rvalid_nxt = 1'b1;
      rd_addr_nxt = s_axi_araddr;
      case (rd_idx)
        IDX_TRIGGER: rd_byte = 8'h00;
        IDX_CHIP_CTRL: begin
          rd_byte[ENABLE_BIT] = enable_r;
          rd_byte[FAIL_BIT] = fail_r;
        end
        IDX_UPD_EN: rd_byte = {5'h00, upd_en_r};
        IDX_ADDR_HI: rd_byte = addr_hi_r;
        IDX_ADDR_LO: rd_byte = addr_lo_r;
        IDX_BUFFER: rd_byte = buffer_r;
        IDX_COMMAND: rd_byte = command_r;
        IDX_UNLOCK: rd_byte = 8'h00;
        IDX_IRQ_MASK: rd_byte = {6'h00, irq_mask_r};
        IDX_IRQ_STAT: begin
          rd_byte = {6'h00, irq_stat_r};
          irq_stat_nxt = 2'h0;
        end
        default: rd_hit = 1'b0;
      endcase
      rdata_nxt = {24'h000000, rd_byte};
      rresp_nxt = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end

    // Completion events come after the bus so a new event beats a clear.
    if (op.done) begin
      hold_nxt = 1'b0;
      if (!op.fail && command_r[3:0] == OP_READ) begin
        buffer_nxt = op.rdata;
      end
    end
    if (op.done && op.fail) begin
      fail_nxt = 1'b1;
    end
    irq_stat_nxt = irq_stat_nxt | irq_set;
    irq_nxt = |(irq_stat_nxt & irq_mask_nxt);
    awready_nxt = !aw_full_nxt;
    wready_nxt = !w_full_nxt;
    arready_nxt = !rvalid_nxt;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      key_r <= KEY_IDLE;
      aw_full_r <= 1'b0;
      aw_addr_r <= '0;
      w_full_r <= 1'b0;
      w_byte_r <= RST_BYTE;
      w_lane_r <= 1'b0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rresp_r <= RESP_OKAY;
      rdata_r <= 32'h00000000;
      rd_addr_r <= '0;
      addr_hi_r <= RST_BYTE;
      addr_lo_r <= RST_BYTE;
      buffer_r <= RST_BYTE;
      command_r <= RST_BYTE;
      upd_en_r <= 3'h0;
      enable_r <= 1'b0;
      fail_r <= 1'b0;
      hold_r <= 1'b0;
      start_r <= 1'b0;
      irq_stat_r <= RST_IRQ;
      irq_mask_r <= RST_IRQ;
      irq_r <= 1'b0;
    end else begin
      key_r <= key_nxt;
      aw_full_r <= aw_full_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_full_r <= w_full_nxt;
      w_byte_r <= w_byte_nxt;
      w_lane_r <= w_lane_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
      rd_addr_r <= rd_addr_nxt;
      addr_hi_r <= addr_hi_nxt;
      addr_lo_r <= addr_lo_nxt;
      buffer_r <= buffer_nxt;
      command_r <= command_nxt;
      upd_en_r <= upd_en_nxt;
      enable_r <= enable_nxt;
      fail_r <= fail_nxt;
      hold_r <= hold_nxt;
      start_r <= start_nxt;
      irq_stat_r <= irq_stat_nxt;
      irq_mask_r <= irq_mask_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;
  assign cpu_hold = hold_r;
  assign irq = irq_r;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_start_needs_key: assert property (start_r |-> $past(key_r) == KEY_ARMED)
    else $error("operation started without unlock key");
  a_start_needs_enable: assert property (start_r |-> $past(enable_r))
    else $error("operation started while disabled");
  a_start_raises_hold: assert property ($rose(start_r) |-> hold_r)
    else $error("start without cpu hold");
  a_hold_until_done: assert property (hold_r && !op.done |=> hold_r)
    else $error("cpu hold dropped before completion");
  a_hold_release: assert property (op.done |=> !hold_r)
    else $error("cpu hold not released after completion");
  a_regs_frozen: assert property (hold_r && $past(hold_r)
    |-> $stable({addr_hi_r, addr_lo_r, command_r}))
    else $error("address or command changed while busy");
  a_go_reads_zero: assert property (rvalid_r && rd_addr_r[AXI_AW-1:2] == IDX_TRIGGER
    |-> rdata_r == 32'h00000000)
    else $error("trigger register read nonzero");
  a_fail_sets: assert property (op.done && op.fail |=> fail_r)
    else $error("failure flag not set");
  a_irq_level: assert property (irq_r == |(irq_stat_r & irq_mask_r))
    else $error("interrupt output disagrees with status and mask");
  a_read_lands: assert property (op.done && !op.fail && command_r[3:0] == OP_READ
    |=> buffer_r == $past(op.rdata))
    else $error("read result missing from byte buffer");

  c_op_started: cover property (start_r ##[1:1000] op.done);
  c_op_failed: cover property (op.done && op.fail);
  c_read_done: cover property (op.done && !op.fail && command_r[3:0] == OP_READ);
  c_irq_seen: cover property ($rose(irq_r));
endmodule // flash_self_program_regs
`default_nettype wire

// ### verif/cpu_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model
  import flash_regs_pkg::*;
(
  // Clock and core stall
  input wire logic aclk,
  input wire logic cpu_hold,
  // Write channels
  output var logic [AXI_AW-1:0] awaddr,
  output var logic awvalid,
  input wire logic awready,
  output var logic [31:0] wdata,
  output var logic [3:0] wstrb,
  output var logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output var logic bready,
  // Read channels
  output var logic [AXI_AW-1:0] araddr,
  output var logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output var logic rready,
  // Raised when a bus wait or a stall never ends
  output var logic hung
);
  logic global_interrupt_enable;

  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready, hung} = '0;
    global_interrupt_enable = 1'b1;
  end

  task automatic wr(input logic [7:0] idx, input logic [7:0] d, output logic [1:0] resp);
    int n;
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    resp = 2'h3;
    awaddr <= {idx, 2'b00};
    wdata <= {24'h000000, d};
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (bvalid) begin
        resp = bresp;
        break;
      end
      if (!aw_ok && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    // Ready drops after each accepted address or data beat until the write fires, so each valid is lowered once, after its own handshake.
    if (n == 64) hung <= 1'b1;
  endtask

  task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] resp);
    int n;
    d = 32'hFFFFFFFF;
    resp = 2'h3;
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (rvalid) begin
        d = rdata;
        resp = rresp;
        break;
      end
      if (arready) arvalid <= 1'b0;
    end
    if (n == 64) hung <= 1'b1;
  endtask

  // Protected writes go straight after the two key bytes; any write in between disarms.
  task automatic kw(input logic [7:0] idx, input logic [7:0] d);
    logic [1:0] r;
    wr(IDX_UNLOCK, KEY_FIRST, r);
    wr(IDX_UNLOCK, KEY_SECOND, r);
    wr(idx, d, r);
  endtask

  task automatic go();
    global_interrupt_enable = 1'b0;
    kw(IDX_TRIGGER, 8'h01);
  endtask

  // The core is stalled, so interrupts come back only once the hold drops.
  task automatic wait_free(output int n);
    n = 0;
    while (cpu_hold !== 1'b0 && n < 2000) begin
      @(posedge aclk);
      n++;
    end
    if (n >= 2000) hung <= 1'b1;
    global_interrupt_enable = 1'b1;
  endtask
endmodule // cpu_core_model
`default_nettype wire

// ### verif/flash_self_program_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module flash_self_program_regs_tb;
  import flash_regs_pkg::*;
  localparam int PROG_CYC = 10;
  localparam int ERASE_LEN = 200;
  logic aclk;
  logic aresetn;
  logic [AXI_AW-1:0] awaddr;
  logic [AXI_AW-1:0] araddr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [31:0] d;
  logic [3:0] wstrb;
  logic [1:0] bresp;
  logic [1:0] rresp;
  logic [1:0] r;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, cpu_hold, irq, hung;
  int fails;
  int n_tests;
  int n;

  flash_self_program_regs #(.AREA_AW(10), .ERASE_CYCLES(ERASE_LEN), .PROGRAM_CYCLES(PROG_CYC))
    flash_self_program_regs_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .cpu_hold(cpu_hold), .irq(irq));

  cpu_core_model cpu_core_model_i (.aclk(aclk), .cpu_hold(cpu_hold),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .hung(hung));

  initial aclk = 1'b0;
  always #2.5 aclk = ~aclk;

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  always @(posedge hung) begin
    fails++;
    wrap_up();
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic rdchk(input string what, input logic [7:0] idx, input logic [7:0] exp);
    cpu_core_model_i.rd(idx, d, r);
    chk(what, d, {24'h000000, exp});
  endtask

  task automatic t_reset();
    rdchk("addr_lo", IDX_ADDR_LO, RST_BYTE);
    rdchk("addr_hi", IDX_ADDR_HI, RST_BYTE);
    rdchk("buffer", IDX_BUFFER, RST_BYTE);
    rdchk("trigger", IDX_TRIGGER, 8'h00);
    rdchk("mask", IDX_IRQ_MASK, {6'h00, RST_IRQ});
    cpu_core_model_i.rd(8'h00, d, r);
    chk("rresp", 32'(r), 32'(RESP_SLVERR));
    cpu_core_model_i.wr(8'h00, 8'hFF, r);
    chk("bresp", 32'(r), 32'(RESP_SLVERR));
  endtask

  task automatic t_addr();
    cpu_core_model_i.wr(IDX_ADDR_LO, 8'hA5, r);
    cpu_core_model_i.wr(IDX_ADDR_HI, 8'h3C, r);
    rdchk("addr_lo", IDX_ADDR_LO, 8'hA5);
    rdchk("addr_hi", IDX_ADDR_HI, 8'h3C);
  endtask

  // A trigger without the key, after a disarming write, or with the engine disabled is ignored.
  task automatic t_locked();
    cpu_core_model_i.wr(IDX_TRIGGER, 8'h01, r);
    chk("hold_nokey", 32'(cpu_hold), 32'h0);
    cpu_core_model_i.wr(IDX_UNLOCK, KEY_FIRST, r);
    cpu_core_model_i.wr(IDX_UNLOCK, KEY_SECOND, r);
    cpu_core_model_i.wr(IDX_ADDR_LO, 8'h10, r);
    cpu_core_model_i.wr(IDX_TRIGGER, 8'h01, r);
    chk("hold_disarm", 32'(cpu_hold), 32'h0);
    cpu_core_model_i.go();
    chk("hold_disabled", 32'(cpu_hold), 32'h0);
  endtask

  task automatic t_program();
    cpu_core_model_i.kw(IDX_CHIP_CTRL, 8'h01);
    cpu_core_model_i.kw(IDX_UPD_EN, 8'h01);
    cpu_core_model_i.wr(IDX_IRQ_MASK, 8'h01, r);
    cpu_core_model_i.wr(IDX_ADDR_LO, 8'h10, r);
    cpu_core_model_i.wr(IDX_ADDR_HI, 8'h00, r);
    cpu_core_model_i.wr(IDX_BUFFER, 8'h5A, r);
    cpu_core_model_i.wr(IDX_COMMAND, 8'h21, r);
    cpu_core_model_i.go();
    chk("hold_start", 32'(cpu_hold), 32'h1);
    cpu_core_model_i.wait_free(n);
    chk("hold_len", 32'(n >= PROG_CYC && n <= PROG_CYC + 8), 32'h1);
    rdchk("trigger", IDX_TRIGGER, 8'h00);
    rdchk("no_fail", IDX_CHIP_CTRL, 8'h01);
    chk("irq_done", 32'(irq), 32'h1);
    rdchk("status", IDX_IRQ_STAT, 8'h01);
    repeat (2) @(posedge aclk);
    chk("irq_clear", 32'(irq), 32'h0);
    cpu_core_model_i.wr(IDX_BUFFER, 8'h00, r);
    cpu_core_model_i.wr(IDX_COMMAND, 8'h00, r);
    cpu_core_model_i.go();
    cpu_core_model_i.wait_free(n);
    rdchk("read_back", IDX_BUFFER, 8'h5A);
  endtask

  // Writes issued while the core is held must not disturb the operands.
  task automatic t_erase();
    cpu_core_model_i.wr(IDX_COMMAND, 8'h22, r);
    cpu_core_model_i.go();
    cpu_core_model_i.wr(IDX_ADDR_LO, 8'h77, r);
    cpu_core_model_i.wr(IDX_ADDR_HI, 8'h01, r);
    cpu_core_model_i.wait_free(n);
    chk("erase_len", 32'(n >= ERASE_LEN - 10), 32'h1);
    rdchk("frozen_lo", IDX_ADDR_LO, 8'h10);
    rdchk("frozen_hi", IDX_ADDR_HI, 8'h00);
  endtask

  // Bad opcode, address past the area, then a program into an area not enabled for update.
  task automatic t_fail();
    logic [7:0] cmds [3];
    logic [7:0] his [3];
    cmds = '{8'h27, 8'h21, 8'h61};
    his = '{8'h00, 8'h04, 8'h00};
    cpu_core_model_i.wr(IDX_IRQ_MASK, 8'h02, r);
    for (int i = 0; i < 3; i++) begin
      cpu_core_model_i.wr(IDX_COMMAND, cmds[i], r);
      cpu_core_model_i.wr(IDX_ADDR_HI, his[i], r);
      cpu_core_model_i.go();
      cpu_core_model_i.wait_free(n);
      rdchk("fail_flag", IDX_CHIP_CTRL, 8'h41);
      chk("irq_fail", 32'(irq), 32'h1);
      rdchk("fail_stat", IDX_IRQ_STAT, 8'h03);
      cpu_core_model_i.kw(IDX_CHIP_CTRL, 8'h01);
      rdchk("fail_clear", IDX_CHIP_CTRL, 8'h01);
    end
  endtask

  initial begin
    fails = 0;
    n_tests = 0;
    aresetn = 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_reset();
    t_addr();
    t_locked();
    t_program();
    t_erase();
    t_fail();
    wrap_up();
  end
endmodule // flash_self_program_regs_tb
`default_nettype wire
